//--- rtl/eoe_pkg.sv
`default_nettype none

package eoe_pkg;

   // ---------------------------------------------------
   // feature-control register layout
   // ---------------------------------------------------
   localparam int unsigned FC_LOCK_POS   = 0;
   localparam int unsigned FC_ENABLE_POS = 18;
   localparam logic        FC_LOCK_RST   = 1'b0;
   localparam logic        FC_ENABLE_RST = 1'b0;

   // ---------------------------------------------------
   // identification leaves and sub-leaves
   // ---------------------------------------------------
   localparam logic [31:0] LEAF_EXT_FEAT = 32'h0000_0007;
   localparam logic [31:0] LEAF_ENCLAVE  = 32'h0000_0012;
   localparam logic [31:0] SUB_CAP       = 32'h0000_0000;
   localparam logic [31:0] SUB_ATTR      = 32'h0000_0001;
   localparam logic [31:0] SUB_SECT_BASE = 32'h0000_0002;
   localparam int unsigned FEAT_SUPPORT_POS = 2;
   localparam int unsigned CAP_BASE_POS     = 0;
   localparam int unsigned CAP_EXT_POS      = 1;

   // ---------------------------------------------------
   // section sub-leaf encodings
   // ---------------------------------------------------
   localparam logic [3:0]  SECT_TYPE_INVALID = 4'h0;
   localparam logic [3:0]  SECT_TYPE_STORE   = 4'h1;
   localparam logic [3:0]  PROT_NONE         = 4'h0;
   localparam logic [3:0]  PROT_CIR          = 4'h1;
   localparam int unsigned SECT_COUNT        = 4;
   localparam int unsigned SECT_IDX_W        = 2;
   localparam int unsigned SECT_FIELD_W      = 40;
   localparam int unsigned SECT_LOW_W        = 20;

   typedef struct packed {
      logic [31:0] d;
      logic [31:0] c;
      logic [31:0] b;
      logic [31:0] a;
   } eoe_words_t;

   // base and size hold address bits 51:12
   typedef struct packed {
      logic                    valid;
      logic [SECT_FIELD_W-1:0] base;
      logic [SECT_FIELD_W-1:0] size;
   } eoe_sect_t;

   typedef struct packed {
      eoe_sect_t [SECT_COUNT-1:0] ent;
   } eoe_tbl_t;

   localparam eoe_sect_t SECT_RST = '0;

endpackage

`default_nettype wire

//--- rtl/eoe_sect_tbl.sv
`default_nettype none

// ---------------------------------------------------
// protected-memory section table
// ---------------------------------------------------
module eoe_sect_tbl (
   input  wire logic                             ref_clk,
   input  wire logic                             sys_rst,
   input  wire logic                             wr_req,
   input  wire logic [eoe_pkg::SECT_IDX_W-1:0]   wr_idx,
   input  wire eoe_pkg::eoe_sect_t               wr_entry,
   input  wire logic [eoe_pkg::SECT_IDX_W-1:0]   rd_idx,
   output      eoe_pkg::eoe_sect_t               rd_entry
);

   eoe_pkg::eoe_tbl_t st_r;
   eoe_pkg::eoe_tbl_t st_nxt;

   // one entry written per request, the rest hold
   always_comb begin
      st_nxt = st_r;
      if (wr_req) begin
         st_nxt.ent[wr_idx] = wr_entry;
      end
   end

   // every section starts out invalid
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= {eoe_pkg::SECT_COUNT{eoe_pkg::SECT_RST}};
      end else begin
         st_r <= st_nxt;
      end
   end

   // read is combinational; the caller registers the answer
   assign rd_entry = st_r.ent[rd_idx];

endmodule

`default_nettype wire

//--- rtl/eoe_top.sv
`default_nettype none

// Function
// - opted in only when lock bit and opt-in enable bit are both one
// - opt-in enable bit obeys the same lock write restriction as other fields
// - opt-in enable bit never shows in any identification answer
// - supported but not opted in gives protection fault; opted in runs
// - no support gives undefined-opcode fault and invalid leaf; extra checks too
// - enclave leaf answered only with support; sub-leaves 1 and up follow opt-in
// - answers come from this thread's own state only
// - configured device returns non-zero content in three or more sub-leaves
// - sub-leaf 0 capability, 1 attributes, 2 and up memory sections
// - sub-leaf 0 word a: bit0 base set, bit1 extended set, rest zero
// - sub-leaf 0 word b carries the misc feature vector
// - sub-leaf 0 word d: legacy and long size log2; word c zero
// - sub-leaf 1 returns the 128-bit settable attribute mask
// - section scan stops at invalid type; invalid sub-leaves read all zero
// - section word a type field 0 invalid, 1 section; bits 11:4 zero
// - section base bits 51:12 spread over words a and b
// - section word c bits 3:0 give the protection code
// - section size bits 51:12 spread over words c and d
// - leaf 07H word b bit 2 reports enclave support
module eoe_top #(
   parameter logic          SUPPORTED       = 1'b1,
   parameter logic          BASE_SET        = 1'b1,
   parameter logic          EXT_SET         = 1'b1,
   parameter logic [31:0]   MISC_VEC        = 32'h0000_0001,
   parameter logic [7:0]    MAX_LOG2_LEGACY = 8'h1F,
   parameter logic [7:0]    MAX_LOG2_LONG   = 8'h24,
   parameter logic [127:0]  ATTR_MASK       = 128'h0000_0000_0000_0003_0000_0000_0000_0036
) (
   input  wire logic                           ref_clk,
   input  wire logic                           sys_rst,
   // feature-control register
   input  wire logic                           fc_wr_req,
   input  wire logic [31:0]                    fc_wr_data,
   output      logic [31:0]                    fc_rd_data,
   output      logic                           fc_wr_refused,
   output      logic                           opted_in,
   // section configuration by system software
   input  wire logic                           sect_wr_req,
   input  wire logic [eoe_pkg::SECT_IDX_W-1:0] sect_wr_idx,
   input  wire eoe_pkg::eoe_sect_t             sect_wr_entry,
   // identification query
   input  wire logic                           q_req,
   input  wire logic [31:0]                    q_leaf,
   input  wire logic [31:0]                    q_subleaf,
   output      logic                           q_ack,
   output      eoe_pkg::eoe_words_t            q_words,
   // enclave instruction gate
   input  wire logic                           instr_req,
   input  wire logic                           instr_extra_ud,
   output      logic                           instr_go,
   output      logic                           fault_ud,
   output      logic                           fault_gp
);

   // ---------------------------------------------------
   // state
   // ---------------------------------------------------
   typedef struct packed {
      logic                fc_lock;
      logic                fc_en;
      logic                refused;
      logic                ack;
      eoe_pkg::eoe_words_t words;
      logic                go;
      logic                ud;
      logic                gp;
   } eoe_state_t;

   eoe_state_t st_r;
   eoe_state_t st_nxt;

   logic                           optin;
   logic [31:0]                    sect_off;
   logic                           sect_in_range;
   logic [eoe_pkg::SECT_IDX_W-1:0] sect_rd_idx;
   eoe_pkg::eoe_sect_t             sect_rd_entry;
   eoe_pkg::eoe_words_t            ans;

   // ---------------------------------------------------
   // word builders
   // ---------------------------------------------------

   // sections pack address bits 51:12 into a low and a high word
   function automatic eoe_pkg::eoe_words_t sect_words(
      input eoe_pkg::eoe_sect_t e
   );
      eoe_pkg::eoe_words_t w;
      w = '0;
      if (e.valid) begin
         w.a[3:0]   = eoe_pkg::SECT_TYPE_STORE;
         w.a[31:12] = e.base[eoe_pkg::SECT_LOW_W-1:0];
         w.b[19:0]  = e.base[eoe_pkg::SECT_FIELD_W-1:eoe_pkg::SECT_LOW_W];
         w.c[3:0]   = eoe_pkg::PROT_CIR;
         w.c[31:12] = e.size[eoe_pkg::SECT_LOW_W-1:0];
         w.d[19:0]  = e.size[eoe_pkg::SECT_FIELD_W-1:eoe_pkg::SECT_LOW_W];
      end
      return w;
   endfunction

   // capability sub-leaf; reserved fields stay zero
   function automatic eoe_pkg::eoe_words_t cap_words();
      eoe_pkg::eoe_words_t w;
      w = '0;
      w.a[eoe_pkg::CAP_BASE_POS] = BASE_SET;
      w.a[eoe_pkg::CAP_EXT_POS]  = EXT_SET;
      w.b                        = MISC_VEC;
      w.d[7:0]                   = MAX_LOG2_LEGACY;
      w.d[15:8]                  = MAX_LOG2_LONG;
      return w;
   endfunction

   // ---------------------------------------------------
   // opt-in decode
   // ---------------------------------------------------

   // both bits are needed; enable alone is not an opt-in
   assign optin    = st_r.fc_lock & st_r.fc_en;
   assign opted_in = optin;

   // only the two implemented bits read back, others zero
   always_comb begin
      fc_rd_data = '0;
      fc_rd_data[eoe_pkg::FC_LOCK_POS]   = st_r.fc_lock;
      fc_rd_data[eoe_pkg::FC_ENABLE_POS] = st_r.fc_en;
   end

   // ---------------------------------------------------
   // section table
   // ---------------------------------------------------

   // sub-leaf index minus two selects the table entry
   assign sect_off      = q_subleaf - eoe_pkg::SUB_SECT_BASE;
   assign sect_in_range = (q_subleaf >= eoe_pkg::SUB_SECT_BASE)
                          && (sect_off < eoe_pkg::SECT_COUNT);
   assign sect_rd_idx   = sect_off[eoe_pkg::SECT_IDX_W-1:0];

   eoe_sect_tbl u_sect_tbl (
      .ref_clk  (ref_clk),
      .sys_rst  (sys_rst),
      .wr_req   (sect_wr_req),
      .wr_idx   (sect_wr_idx),
      .wr_entry (sect_wr_entry),
      .rd_idx   (sect_rd_idx),
      .rd_entry (sect_rd_entry)
   );

   // ---------------------------------------------------
   // query decode
   // ---------------------------------------------------

   // answers depend only on this thread's own copy of the state,
   // so one instance per hardware thread keeps them apart
   always_comb begin
      ans = '0;
      if (q_leaf == eoe_pkg::LEAF_EXT_FEAT) begin
         if (q_subleaf == eoe_pkg::SUB_CAP) begin
            // enable bit deliberately not visible here
            ans.b[eoe_pkg::FEAT_SUPPORT_POS] = SUPPORTED;
         end
      end else if (q_leaf == eoe_pkg::LEAF_ENCLAVE && SUPPORTED) begin
         if (q_subleaf == eoe_pkg::SUB_CAP) begin
            ans = cap_words();
         end else if (q_subleaf == eoe_pkg::SUB_ATTR) begin
            if (optin) begin
               ans = ATTR_MASK;
            end
         end else if (sect_in_range && optin) begin
            // unconfigured entries fall out as all-zero
            ans = sect_words(sect_rd_entry);
         end
      end
   end

   // ---------------------------------------------------
   // next state
   // ---------------------------------------------------
   always_comb begin
      st_nxt         = st_r;
      st_nxt.refused = 1'b0;
      st_nxt.ack     = q_req;
      st_nxt.go      = 1'b0;
      st_nxt.ud      = 1'b0;
      st_nxt.gp      = 1'b0;

      // a set lock freezes the whole register, enable included
      if (fc_wr_req) begin
         if (st_r.fc_lock) begin
            st_nxt.refused = 1'b1;
         end else begin
            st_nxt.fc_lock = fc_wr_data[eoe_pkg::FC_LOCK_POS];
            st_nxt.fc_en   = fc_wr_data[eoe_pkg::FC_ENABLE_POS];
         end
      end

      // words hold between queries so a slow reader still sees them
      if (q_req) begin
         st_nxt.words = ans;
      end

      // undefined-opcode checks outrank the opt-in check
      if (instr_req) begin
         if (!SUPPORTED || instr_extra_ud) begin
            st_nxt.ud = 1'b1;
         end else if (!optin) begin
            st_nxt.gp = 1'b1;
         end else begin
            st_nxt.go = 1'b1;
         end
      end
   end

   // ---------------------------------------------------
   // registers
   // ---------------------------------------------------

   // lock and enable clear so instructions fault until reconfigured
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r         <= '0;
         st_r.fc_lock <= eoe_pkg::FC_LOCK_RST;
         st_r.fc_en   <= eoe_pkg::FC_ENABLE_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign fc_wr_refused = st_r.refused;
   assign q_ack         = st_r.ack;
   assign q_words       = st_r.words;
   assign instr_go      = st_r.go;
   assign fault_ud      = st_r.ud;
   assign fault_gp      = st_r.gp;

   // ---------------------------------------------------
   // checks
   // ---------------------------------------------------

   a_gp_not_optin : assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      instr_req && SUPPORTED && !instr_extra_ud && !optin
      |=> fault_gp && !instr_go && !fault_ud
   ) else $error("protection fault missing without opt-in");

   a_go_optin : assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      instr_go |-> $past(fc_rd_data[eoe_pkg::FC_LOCK_POS])
                   && $past(fc_rd_data[eoe_pkg::FC_ENABLE_POS])
   ) else $error("instruction ran without both bits set");

   a_ud_first : assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      instr_req && (!SUPPORTED || instr_extra_ud)
      |=> fault_ud && !fault_gp && !instr_go
   ) else $error("undefined-opcode fault missing");

   a_lock_freeze : assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      fc_wr_req && fc_rd_data[eoe_pkg::FC_LOCK_POS]
      |=> fc_wr_refused && $stable(fc_rd_data)
   ) else $error("locked register was changed");

   a_support_flag : assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      q_req && q_leaf == eoe_pkg::LEAF_EXT_FEAT && q_subleaf == eoe_pkg::SUB_CAP
      |=> q_ack && q_words.b[eoe_pkg::FEAT_SUPPORT_POS] == SUPPORTED
          && (q_words.b & ~(32'h0000_0001 << eoe_pkg::FEAT_SUPPORT_POS)) == '0
          && q_words.a == '0 && q_words.c == '0 && q_words.d == '0
   ) else $error("support flag answer wrong");

   a_cap_reserved : assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      q_req && q_leaf == eoe_pkg::LEAF_ENCLAVE && q_subleaf == eoe_pkg::SUB_CAP
      |=> q_words.a[31:2] == '0 && q_words.c == '0 && q_words.d[31:16] == '0
          && q_words.d[15:8] == (SUPPORTED ? MAX_LOG2_LONG : 8'h00)
   ) else $error("capability reserved fields not zero");

   a_unsupported_zero : assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      q_req && q_leaf == eoe_pkg::LEAF_ENCLAVE && !SUPPORTED
      |=> q_ack && q_words == '0
   ) else $error("enclave leaf answered without support");

   a_invalid_zero : assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      q_ack && $past(q_leaf) == eoe_pkg::LEAF_ENCLAVE
      && $past(q_subleaf) >= eoe_pkg::SUB_SECT_BASE
      && q_words.a[3:0] == eoe_pkg::SECT_TYPE_INVALID
      |-> q_words == '0
   ) else $error("invalid section sub-leaf not zero");

   a_sect_reserved : assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      q_ack && $past(q_leaf) == eoe_pkg::LEAF_ENCLAVE
      && $past(q_subleaf) >= eoe_pkg::SUB_SECT_BASE
      |-> q_words.a[11:4] == '0 && q_words.b[31:20] == '0
          && q_words.c[11:4] == '0 && q_words.d[31:20] == '0
   ) else $error("section reserved fields not zero");

   a_ack_timing : assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      q_req |=> q_ack ##1 (q_ack == $past(q_req))
   ) else $error("query answer not one cycle later");

   a_fc_accept : assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      fc_wr_req && !fc_rd_data[eoe_pkg::FC_LOCK_POS]
      |=> !fc_wr_refused && fc_rd_data[eoe_pkg::FC_LOCK_POS] == $past(fc_wr_data[eoe_pkg::FC_LOCK_POS])
          && fc_rd_data[eoe_pkg::FC_ENABLE_POS] == $past(fc_wr_data[eoe_pkg::FC_ENABLE_POS])
   ) else $error("unlocked write not taken");

   a_attr_gated : assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      q_req && q_leaf == eoe_pkg::LEAF_ENCLAVE && q_subleaf == eoe_pkg::SUB_ATTR && SUPPORTED
      |=> q_words == ($past(opted_in) ? ATTR_MASK : 128'h0)
   ) else $error("attribute mask answer wrong");

   a_cap_fields : assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      q_req && q_leaf == eoe_pkg::LEAF_ENCLAVE && q_subleaf == eoe_pkg::SUB_CAP && SUPPORTED
      |=> q_words.a[1:0] == {EXT_SET, BASE_SET} && q_words.b == MISC_VEC
          && q_words.d[7:0] == MAX_LOG2_LEGACY
   ) else $error("capability fields wrong");

   a_sect_codes : assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      q_ack && $past(q_leaf) == eoe_pkg::LEAF_ENCLAVE
      && $past(q_subleaf) >= eoe_pkg::SUB_SECT_BASE
      && q_words.a[3:0] != eoe_pkg::SECT_TYPE_INVALID
      |-> q_words.a[3:0] == eoe_pkg::SECT_TYPE_STORE && q_words.c[3:0] == eoe_pkg::PROT_CIR
   ) else $error("section type or protection code wrong");

   a_sect_closed : assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      q_req && q_leaf == eoe_pkg::LEAF_ENCLAVE && q_subleaf >= eoe_pkg::SUB_SECT_BASE && !optin
      |=> q_words == '0
   ) else $error("section reported without opt-in");

   a_one_outcome : assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      instr_req
      |=> $onehot({instr_go, fault_ud, fault_gp})
   ) else $error("instruction outcome not exactly one");

endmodule

`default_nettype wire

//--- testbench/eoe_sw_model.sv
`default_nettype none

// ---------------------------------------------------
// software side: issues identification queries
// ---------------------------------------------------
module eoe_sw_model (
   input  wire logic                ref_clk,
   input  wire logic                q_ack,
   input  wire eoe_pkg::eoe_words_t q_words,
   output var  logic                q_req,
   output var  logic [31:0]         q_leaf,
   output var  logic [31:0]         q_subleaf
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      q_req     = 1'b0;
      q_leaf    = '0;
      q_subleaf = '0;
   end

   // one-cycle request, since holding it would ask again; answer read mid-cycle
   // released lines show the inverse, not stale data
   task automatic query(input logic [31:0] leaf, input logic [31:0] sub,
                        output eoe_pkg::eoe_words_t w, output logic ok);
      ok = 1'b0;
      w  = '0;
      @(posedge ref_clk);
      q_req     <= 1'b1;
      q_leaf    <= leaf;
      q_subleaf <= sub;
      for (int n = 0; n < 8 && !ok; n++) begin
         @(posedge ref_clk);
         q_req     <= 1'b0;
         q_leaf    <= ~leaf;
         q_subleaf <= ~sub;
         @(negedge ref_clk);
         if (q_ack === 1'b1) begin
            ok = 1'b1;
            w  = q_words;
         end
      end
   endtask

   // walk sections upward from sub-leaf 2, stop at the first invalid type
   task automatic scan(output int cnt);
      eoe_pkg::eoe_words_t w;
      logic                ok;
      cnt = -1;
      do begin
         query(eoe_pkg::LEAF_ENCLAVE, eoe_pkg::SUB_SECT_BASE + 32'(cnt + 1), w, ok);
         cnt++;
      end while (ok && w.a[3:0] === eoe_pkg::SECT_TYPE_STORE && cnt < 8);
   endtask
endmodule

`default_nettype wire

//--- testbench/tb.sv
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [31:0]  P_MISC = 32'h0000_0005;
   localparam logic [7:0]   P_LEG  = 8'h1F;
   localparam logic [7:0]   P_LONG = 8'h24;
   localparam logic [127:0] P_ATTR = 128'h0000_0000_0000_0003_0000_0000_0000_0036;
   localparam logic [127:0] L7     = {64'h0, 32'h0000_0004, 32'h0};

   logic                  ref_clk, sys_rst, fc_wr_req, fc_wr_refused, opted_in, sect_wr_req;
   logic                  q_req, q_ack, instr_req, instr_extra_ud, instr_go, fault_ud;
   logic                  fault_gp, nu_ud;
   logic [31:0]           fc_wr_data, fc_rd_data, q_leaf, q_subleaf;
   logic [1:0]            sect_wr_idx;
   eoe_pkg::eoe_sect_t    sect_wr_entry;
   eoe_pkg::eoe_words_t   q_words, nu_words;
   int                    miscompares, samples_checked;

   // thread with support, and a second thread without it on the same inputs
   eoe_top #(.MISC_VEC(P_MISC), .MAX_LOG2_LEGACY(P_LEG), .MAX_LOG2_LONG(P_LONG),
             .ATTR_MASK(P_ATTR)) u_eoe_top (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .fc_wr_req(fc_wr_req), .fc_wr_data(fc_wr_data),
      .fc_rd_data(fc_rd_data), .fc_wr_refused(fc_wr_refused), .opted_in(opted_in),
      .sect_wr_req(sect_wr_req), .sect_wr_idx(sect_wr_idx), .sect_wr_entry(sect_wr_entry),
      .q_req(q_req), .q_leaf(q_leaf), .q_subleaf(q_subleaf), .q_ack(q_ack),
      .q_words(q_words), .instr_req(instr_req), .instr_extra_ud(instr_extra_ud),
      .instr_go(instr_go), .fault_ud(fault_ud), .fault_gp(fault_gp));
   eoe_top #(.SUPPORTED(1'b0)) u_eoe_top_nosup (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .fc_wr_req(fc_wr_req), .fc_wr_data(fc_wr_data),
      .fc_rd_data(), .fc_wr_refused(), .opted_in(),
      .sect_wr_req(sect_wr_req), .sect_wr_idx(sect_wr_idx), .sect_wr_entry(sect_wr_entry),
      .q_req(q_req), .q_leaf(q_leaf), .q_subleaf(q_subleaf), .q_ack(),
      .q_words(nu_words), .instr_req(instr_req), .instr_extra_ud(instr_extra_ud),
      .instr_go(), .fault_ud(nu_ud), .fault_gp());
   eoe_sw_model u_eoe_sw_model (.ref_clk(ref_clk), .q_ack(q_ack), .q_words(q_words),
      .q_req(q_req), .q_leaf(q_leaf), .q_subleaf(q_subleaf));

   always #5 ref_clk = ~ref_clk;

   // ---------------------------------------------------
   // shared checking and driving tasks
   // ---------------------------------------------------
   task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // a hung query counts as a mismatch and ends the run
   task automatic q(input string what, input logic [31:0] leaf, input logic [31:0] sub,
                    input logic [127:0] exp);
      eoe_pkg::eoe_words_t w;
      logic                ok;
      u_eoe_sw_model.query(leaf, sub, w, ok);
      if (ok !== 1'b1) begin
         miscompares++;
         summarize();
      end
      check(what, w, exp);
      check("unsupported thread words", nu_words, '0);
   endtask

   // exp is {read data, opted in, refused}, seen half a cycle after the write is taken
   task automatic fc(input logic [31:0] data, input logic [33:0] exp);
      @(posedge ref_clk);
      fc_wr_req  <= 1'b1;
      fc_wr_data <= data;
      @(posedge ref_clk);
      fc_wr_req  <= 1'b0;
      fc_wr_data <= ~data;
      @(negedge ref_clk);
      check("feature control", 128'({fc_rd_data, opted_in, fc_wr_refused}), 128'(exp));
   endtask

   // exp is {go, undefined, protection}
   task automatic instr(input logic extra, input logic [2:0] exp);
      @(posedge ref_clk);
      instr_req      <= 1'b1;
      instr_extra_ud <= extra;
      @(posedge ref_clk);
      instr_req      <= 1'b0;
      instr_extra_ud <= ~extra;
      @(negedge ref_clk);
      check("instr outcome", 128'({instr_go, fault_ud, fault_gp}), 128'(exp));
      check("unsupported thread fault", 128'(nu_ud), 128'(1'b1));
   endtask

   task automatic sect(input logic [1:0] idx, input eoe_pkg::eoe_sect_t e);
      @(posedge ref_clk);
      sect_wr_req   <= 1'b1;
      sect_wr_idx   <= idx;
      sect_wr_entry <= e;
      @(posedge ref_clk);
      sect_wr_req   <= 1'b0;
      sect_wr_entry <= ~e;
   endtask

   task automatic do_reset();
      @(posedge ref_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      check("reset state", 128'({fc_rd_data, opted_in}), '0);
      @(posedge ref_clk);
      sys_rst <= 1'b0;
   endtask

   function automatic logic [127:0] sw(input eoe_pkg::eoe_sect_t e);
      return {12'h000, e.size, 8'h00, eoe_pkg::PROT_CIR,
              12'h000, e.base, 8'h00, eoe_pkg::SECT_TYPE_STORE};
   endfunction

   // ---------------------------------------------------
   // scenarios
   // ---------------------------------------------------
   // enable alone must keep instructions faulting; after lock alone and a locked write only an instruction with an extra undefined-opcode check is driven
   task automatic t_gate();
      q("leaf 7", eoe_pkg::LEAF_EXT_FEAT, 32'h0, L7);
      q("attr closed", eoe_pkg::LEAF_ENCLAVE, eoe_pkg::SUB_ATTR, '0);
      instr(1'b0, 3'b001);
      fc(32'h0004_0000, {32'h0004_0000, 2'b00});
      instr(1'b0, 3'b001);
      q("leaf 7 enable set", eoe_pkg::LEAF_EXT_FEAT, 32'h0, L7);
      do_reset();
      fc(32'h0000_0001, {32'h0000_0001, 2'b00});
      fc(32'h0004_0001, {32'h0000_0001, 2'b01});
      instr(1'b1, 3'b010);
      do_reset();
      $display("t_gate done");
   endtask

   task automatic t_enum();
      eoe_pkg::eoe_sect_t e0, e1, e2, e3;
      int                 n;
      e0 = '{1'b1, 40'h12345_6789A, 40'hFEDCB_A9876};
      e1 = '{1'b1, 40'h00000_00100, 40'h00000_00001};
      e2 = '{1'b0, 40'h55555_55555, 40'h33333_33333};
      e3 = '{1'b1, 40'h0000F_00000, 40'h00000_20000};
      fc(32'hFFFF_FFFF, {32'h0004_0001, 2'b10});
      fc(32'h0000_0000, {32'h0004_0001, 2'b11});
      instr(1'b0, 3'b100);
      instr(1'b1, 3'b010);
      q("leaf 7 opted", eoe_pkg::LEAF_EXT_FEAT, 32'h0, L7);
      q("capability", eoe_pkg::LEAF_ENCLAVE, eoe_pkg::SUB_CAP,
        {16'h0, P_LONG, P_LEG, 32'h0, P_MISC, 30'h0, 2'b11});
      q("attr mask", eoe_pkg::LEAF_ENCLAVE, eoe_pkg::SUB_ATTR, P_ATTR);
      // sections are only configured once the opt-in is locked in
      sect(2'd0, e0);
      sect(2'd1, e1);
      sect(2'd2, e2);
      sect(2'd3, e3);
      q("section 2", eoe_pkg::LEAF_ENCLAVE, 32'h2, sw(e0));
      q("section 3", eoe_pkg::LEAF_ENCLAVE, 32'h3, sw(e1));
      q("section 4", eoe_pkg::LEAF_ENCLAVE, 32'h4, '0);
      q("section 6", eoe_pkg::LEAF_ENCLAVE, 32'h6, '0);
      q("unknown leaf", 32'h0000_0013, 32'h0, '0);
      u_eoe_sw_model.scan(n);
      check("scan stop index", 128'(n), 128'(2));
      $display("t_enum done");
   endtask

   initial begin
      ref_clk         = 1'b0;
      sys_rst         = 1'b1;
      fc_wr_req       = 1'b0;
      fc_wr_data      = '0;
      sect_wr_req     = 1'b0;
      sect_wr_idx     = '0;
      sect_wr_entry   = '0;
      instr_req       = 1'b0;
      instr_extra_ud  = 1'b0;
      miscompares     = 0;
      samples_checked = 0;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      t_gate();
      t_enum();
      summarize();
   end
endmodule

`default_nettype wire
